//--- vsf_pkg.sv
// Purpose: Shared constants, types and tables of the valley select and fault logic
// Assumes: 100 MHz core clock, comparator outputs as active-high levels
// Notes: Long counts are defaults for top-level parameters
package vsf_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned NS_PER_US = 1000;
    localparam int unsigned US_PER_MS = 1000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned TIMEOUT_NS = 6500;
    localparam int unsigned TIMEOUT_CYC = (TIMEOUT_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int unsigned WSHORT_MS = 90;
    localparam int unsigned WSHORT_CYC = WSHORT_MS * US_PER_MS * CLK_MHZ;
    localparam int unsigned RESTART_S = 4;
    localparam int unsigned RESTART_CYC = RESTART_S * MS_PER_S * US_PER_MS * CLK_MHZ;
    localparam int unsigned BROWNOUT_MS = 50;
    localparam int unsigned BROWNOUT_CYC = BROWNOUT_MS * US_PER_MS * CLK_MHZ;
    localparam int unsigned BLANK_NS = 300;
    localparam int unsigned BLANK_CYC = (BLANK_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam logic [6:0] FFWD_MIN_PCT = 7'h06;
    // Synchronised comparator inputs
    localparam int IN_VALLEY = 0;
    localparam int IN_WSHORT = 1;
    localparam int IN_LINE_2P4 = 2;
    localparam int IN_LINE_2P3 = 3;
    localparam int IN_LINE_1P0 = 4;
    localparam int IN_LINE_0P9 = 5;
    localparam int IN_CS_LOW = 6;
    localparam int IN_UNLATCH = 7;
    localparam int IN_VCC_ON = 8;
    localparam int IN_W = 9;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SETPOINT = 8'h04;
    localparam logic [7:0] REG_ONTIME = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_MASK = 8'h10;
    localparam logic [7:0] REG_STATE = 8'h14;
    // Field positions
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_LATCH = 1;
    localparam int EV_WSHORT = 0;
    localparam int EV_BROWNOUT = 1;
    localparam int EV_CS_SHORT = 2;
    localparam int EV_TIMEOUT = 3;
    localparam int EV_VALLEY = 4;
    localparam int EV_W = 5;
    localparam int SF_VALLEY = 0;
    localparam int SF_HIGH = 4;
    localparam int SF_BAND = 5;
    localparam int SF_STATE = 8;
    localparam int SF_GATE = 11;
    // Reset values and last band index
    localparam logic [6:0] SETPOINT_RST = 7'h64;
    localparam logic [15:0] ONTIME_RST = 16'h0064;
    localparam logic [2:0] BAND_LAST = 3'h5;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RUN, ST_RESTART_WAIT, ST_LATCHED, ST_BROWNOUT, ST_CS_WAIT
    } vsf_state_e;

    typedef enum logic {PH_WAIT, PH_ON} vsf_phase_e;

    // Valley number per current band, low or high line column
    function automatic logic [3:0] vsf_valley_of(input logic [2:0] band, input logic high_line);
        logic [3:0] v;
        v = 4'h1;
        case (band)
            3'h0: v = high_line ? 4'h2 : 4'h1;
            3'h1: v = high_line ? 4'h3 : 4'h2;
            3'h2: v = high_line ? 4'h5 : 4'h4;
            3'h3: v = high_line ? 4'h8 : 4'h7;
            3'h4: v = high_line ? 4'hC : 4'hB;
            default: v = high_line ? 4'hF : 4'hD;
        endcase
        return v;
    endfunction

    // Set-point below which band k is entered when falling
    function automatic logic [6:0] vsf_fall_edge(input logic [2:0] k);
        logic [6:0] e;
        e = 7'h00;
        case (k)
            3'h1: e = 7'h4B;
            3'h2: e = 7'h32;
            3'h3: e = 7'h1E;
            3'h4: e = 7'h0F;
            3'h5: e = 7'h06;
            default: e = 7'h00;
        endcase
        return e;
    endfunction

    // Set-point at or above which band k is left when rising
    function automatic logic [6:0] vsf_rise_edge(input logic [2:0] k);
        logic [6:0] e;
        e = 7'h7F;
        case (k)
            3'h1: e = 7'h4E;
            3'h2: e = 7'h35;
            3'h3: e = 7'h21;
            3'h4: e = 7'h14;
            3'h5: e = 7'h08;
            default: e = 7'h7F;
        endcase
        return e;
    endfunction
endpackage

//--- vsf_sync.sv
// Purpose: Two-flop synchroniser bank for comparator inputs
// Assumes: Inputs are asynchronous levels
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
module vsf_sync
    import vsf_pkg::*;
#(
    parameter int W = IN_W
)
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } vsf_sync_s;

    vsf_sync_s r;
    vsf_sync_s next_r;

    always_comb
    begin
        next_r = r;
        next_r.s1 = d_i;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign q_o = r.s2;
endmodule // vsf_sync

//--- vsf_top.sv
// Purpose: Valley selection, valley timeout, fault timers and gate enable
// Assumes: Comparators give active-high levels; APB3 slave, one wait state
// Notes: Long durations are parameters so simulation can shorten them
`timescale 1ns/100ps
// Functional notes
// - Band and line range map to valley 1,2,4,7,11,13 or 2,3,5,8,12,15
// - Band edges fall at 75,50,30,15,6 percent, rise at 78,53,33,20,8
// - Line above 2.4 V selects the high-line column
// - High-line column is left only when line drops below 2.3 V
// - Each drop of zero-cross sense below valley threshold is a valley
// - Below threshold 6.5 us without new valley makes a substitute pulse
// - Substitute pulses count as valleys
// - Winding-short timer reaching 90 ms stops gate pulses as a fault
// - Auto-restart variant resumes switching 4 s after winding fault
// - Latching variant holds fault until supply drops below unlatch level
// - Feed-forward enabled only while gate on and set-point above 6 percent
// - Start-up permitted only when line is above 1 V
// - Line below 0.9 V for 50 ms shuts down; any recovery restarts timer
// - Leaving brown-out enters start-up immediately
// - Sense still low after blanking while on shuts down until next hiccup
// - Chosen valley holds until band or range passes a hysteresis edge
module vsf_top
    import vsf_pkg::*;
#(
    parameter int unsigned WSHORT_CYCLES = WSHORT_CYC,
    parameter int unsigned RESTART_CYCLES = RESTART_CYC,
    parameter int unsigned BROWNOUT_CYCLES = BROWNOUT_CYC
)
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic valley_cmp_i,
    input wire logic winding_short_cmp_i,
    input wire logic line_above_2p4_i,
    input wire logic line_above_2p3_i,
    input wire logic line_above_1p0_i,
    input wire logic line_above_0p9_i,
    input wire logic cs_low_cmp_i,
    input wire logic supply_unlatch_i,
    input wire logic supply_on_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic gate_drive_out_o,
    output logic ffwd_en_o,
    output logic irq_o
);
    typedef struct packed {
        vsf_state_e st;
        vsf_phase_e ph;
        logic high_line;
        logic [2:0] band;
        logic [3:0] valley_cnt;
        logic [31:0] tmo_cnt;
        logic [31:0] wshort_cnt;
        logic [31:0] bo_cnt;
        logic [31:0] wait_cnt;
        logic [15:0] on_cnt;
        logic [31:0] blank_cnt;
        logic valley_prev;
        logic vcc_on_prev;
        logic enable;
        logic latch_mode;
        logic [6:0] setpoint;
        logic [15:0] ontime;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic gate;
        logic ffwd;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } vsf_top_s;

    vsf_top_s r;
    vsf_top_s next_r;
    logic [IN_W-1:0] raw_in;
    logic [IN_W-1:0] sin;

    assign raw_in = {supply_on_i, supply_unlatch_i, cs_low_cmp_i, line_above_0p9_i,
                     line_above_1p0_i, line_above_2p3_i, line_above_2p4_i,
                     winding_short_cmp_i, valley_cmp_i};

    vsf_sync #(
        .W(IN_W)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .d_i(raw_in),
        .q_o(sin)
    );

    always_comb
    begin
        logic valley_ev;
        logic tmo_ev;
        logic count_ev;
        logic wshort_hit;
        logic bo_hit;
        logic cs_hit;
        logic vcc_rise;
        logic wr;
        logic rd;
        logic [EV_W-1:0] ev_set;
        logic [EV_W-1:0] ev_clr;
        logic [31:0] rdata;
        logic [3:0] vsel;
        valley_ev = 1'b0;
        tmo_ev = 1'b0;
        count_ev = 1'b0;
        wshort_hit = 1'b0;
        bo_hit = 1'b0;
        cs_hit = 1'b0;
        vcc_rise = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        ev_set = '0;
        ev_clr = '0;
        rdata = '0;
        vsel = vsf_valley_of(r.band, r.high_line);
        next_r = r;

        next_r.valley_prev = sin[IN_VALLEY];
        next_r.vcc_on_prev = sin[IN_VCC_ON];
        vcc_rise = sin[IN_VCC_ON] & ~r.vcc_on_prev;

        // Line range with hysteresis
        if (!r.high_line && sin[IN_LINE_2P4])
        begin
            next_r.high_line = 1'b1;
        end
        else if (r.high_line && !sin[IN_LINE_2P3])
        begin
            next_r.high_line = 1'b0;
        end

        // Current band with hysteresis, one step per cycle
        if (r.band < BAND_LAST && r.setpoint < vsf_fall_edge(r.band + 3'h1))
        begin
            next_r.band = r.band + 3'h1;
        end
        else if (r.band != 3'h0 && r.setpoint >= vsf_rise_edge(r.band))
        begin
            next_r.band = r.band - 3'h1;
        end

        // Valley detection and timeout
        valley_ev = sin[IN_VALLEY] & ~r.valley_prev;
        if (!sin[IN_VALLEY] || valley_ev)
        begin
            next_r.tmo_cnt = '0;
        end
        else if (r.tmo_cnt == TIMEOUT_CYC - 1)
        begin
            next_r.tmo_cnt = '0;
            tmo_ev = 1'b1;
        end
        else
        begin
            next_r.tmo_cnt = r.tmo_cnt + 32'h1;
        end
        count_ev = valley_ev | tmo_ev;

        // Winding short timer
        if (!sin[IN_WSHORT] || r.st != ST_RUN)
        begin
            next_r.wshort_cnt = '0;
        end
        else if (r.wshort_cnt == WSHORT_CYCLES - 1)
        begin
            wshort_hit = 1'b1;
            next_r.wshort_cnt = '0;
        end
        else
        begin
            next_r.wshort_cnt = r.wshort_cnt + 32'h1;
        end

        // Brown-out qualification, restarted by any recovery
        if (sin[IN_LINE_0P9] || r.st != ST_RUN)
        begin
            next_r.bo_cnt = '0;
        end
        else if (r.bo_cnt == BROWNOUT_CYCLES - 1)
        begin
            bo_hit = 1'b1;
            next_r.bo_cnt = '0;
        end
        else
        begin
            next_r.bo_cnt = r.bo_cnt + 32'h1;
        end

        // Switching cycle
        if (r.st == ST_RUN && r.ph == PH_ON)
        begin
            if (r.blank_cnt < BLANK_CYC)
            begin
                next_r.blank_cnt = r.blank_cnt + 32'h1;
            end
            else if (sin[IN_CS_LOW])
            begin
                cs_hit = 1'b1;
            end
            if (r.on_cnt >= r.ontime)
            begin
                next_r.gate = 1'b0;
                next_r.ph = PH_WAIT;
            end
            else
            begin
                next_r.on_cnt = r.on_cnt + 16'h1;
            end
        end
        else if (r.st == ST_RUN && count_ev)
        begin
            if (r.valley_cnt + 4'h1 >= vsel)
            begin
                next_r.valley_cnt = '0;
                next_r.gate = 1'b1;
                next_r.ph = PH_ON;
                next_r.on_cnt = '0;
                next_r.blank_cnt = '0;
            end
            else
            begin
                next_r.valley_cnt = r.valley_cnt + 4'h1;
            end
        end

        // Operating state
        case (r.st)
            ST_IDLE:
            begin
                if (r.enable && sin[IN_LINE_1P0])
                begin
                    next_r.st = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (wshort_hit)
                begin
                    next_r.st = r.latch_mode ? ST_LATCHED : ST_RESTART_WAIT;
                    next_r.wait_cnt = '0;
                end
                else if (bo_hit)
                begin
                    next_r.st = ST_BROWNOUT;
                end
                else if (cs_hit)
                begin
                    next_r.st = ST_CS_WAIT;
                end
            end
            ST_RESTART_WAIT:
            begin
                if (r.wait_cnt == RESTART_CYCLES - 1)
                begin
                    next_r.st = ST_IDLE;
                end
                else
                begin
                    next_r.wait_cnt = r.wait_cnt + 32'h1;
                end
            end
            ST_LATCHED:
            begin
                if (sin[IN_UNLATCH])
                begin
                    next_r.st = ST_IDLE;
                end
            end
            ST_BROWNOUT:
            begin
                if (sin[IN_LINE_1P0])
                begin
                    next_r.st = ST_RUN;
                end
            end
            ST_CS_WAIT:
            begin
                if (vcc_rise)
                begin
                    next_r.st = ST_IDLE;
                end
            end
            default:
            begin
                next_r.st = ST_IDLE;
            end
        endcase
        if (!r.enable)
        begin
            next_r.st = ST_IDLE;
        end
        if (next_r.st != ST_RUN)
        begin
            next_r.gate = 1'b0;
            next_r.ph = PH_WAIT;
            next_r.valley_cnt = '0;
        end
        next_r.ffwd = next_r.gate && (r.setpoint > FFWD_MIN_PCT);

        // APB slave, one wait state
        wr = psel_i & penable_i & pwrite_i & r.pready;
        rd = psel_i & penable_i & ~pwrite_i & ~r.pready;
        next_r.pready = psel_i & penable_i & ~r.pready;
        next_r.pslverr = 1'b0;
        if (psel_i && penable_i && !r.pready)
        begin
            case (paddr_i)
                REG_CTRL, REG_SETPOINT, REG_ONTIME, REG_STATUS, REG_MASK, REG_STATE:
                begin
                    next_r.pslverr = 1'b0;
                end
                default:
                begin
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        case (paddr_i)
            REG_CTRL:
            begin
                rdata[CTRL_ENABLE] = r.enable;
                rdata[CTRL_LATCH] = r.latch_mode;
            end
            REG_SETPOINT:
            begin
                rdata[6:0] = r.setpoint;
            end
            REG_ONTIME:
            begin
                rdata[15:0] = r.ontime;
            end
            REG_STATUS:
            begin
                rdata[EV_W-1:0] = r.status;
            end
            REG_MASK:
            begin
                rdata[EV_W-1:0] = r.mask;
            end
            REG_STATE:
            begin
                rdata[SF_VALLEY +: 4] = vsel;
                rdata[SF_HIGH] = r.high_line;
                rdata[SF_BAND +: 3] = r.band;
                rdata[SF_STATE +: 3] = r.st;
                rdata[SF_GATE] = r.gate;
            end
            default:
            begin
                rdata = '0;
            end
        endcase
        next_r.prdata = rd ? rdata : '0;
        if (wr)
        begin
            case (paddr_i)
                REG_CTRL:
                begin
                    next_r.enable = pwdata_i[CTRL_ENABLE];
                    next_r.latch_mode = pwdata_i[CTRL_LATCH];
                end
                REG_SETPOINT:
                begin
                    next_r.setpoint = pwdata_i[6:0];
                end
                REG_ONTIME:
                begin
                    next_r.ontime = pwdata_i[15:0];
                end
                REG_STATUS:
                begin
                    ev_clr = pwdata_i[EV_W-1:0];
                end
                REG_MASK:
                begin
                    next_r.mask = pwdata_i[EV_W-1:0];
                end
                default:
                begin
                    ev_clr = '0;
                end
            endcase
        end

        // Sticky events, set wins over clear
        ev_set[EV_WSHORT] = wshort_hit;
        ev_set[EV_BROWNOUT] = bo_hit;
        ev_set[EV_CS_SHORT] = cs_hit;
        ev_set[EV_TIMEOUT] = tmo_ev;
        ev_set[EV_VALLEY] = valley_ev;
        next_r.status = (r.status & ~ev_clr) | ev_set;
        next_r.irq = |(next_r.status & next_r.mask);
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            r <= '0;
            r.st <= ST_IDLE;
            r.ph <= PH_WAIT;
            r.setpoint <= SETPOINT_RST;
            r.ontime <= ONTIME_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign prdata_o = r.prdata;
    assign pready_o = r.pready;
    assign pslverr_o = r.pslverr;
    assign gate_drive_out_o = r.gate;
    assign ffwd_en_o = r.ffwd;
    assign irq_o = r.irq;
endmodule // vsf_top

//--- vsf_analog_model.sv
// Purpose: Comparator and power stage model facing vsf_top
// Assumes: Line level given in millivolts by the bench
// Notes: After turn-off a 64 cycle plateau, then ringing of period 32
`timescale 1ns/100ps
module vsf_analog_model
(
    input wire logic ref_clk_i,
    input wire logic gate_i,
    input wire logic damped_i,
    input wire logic wshort_i,
    input wire logic cs_short_i,
    input wire logic [12:0] line_mv_i,
    output logic valley_o,
    output logic wshort_o,
    output logic above_2p4_o,
    output logic above_2p3_o,
    output logic above_1p0_o,
    output logic above_0p9_o,
    output logic cs_low_o
);
    logic [7:0] ring = 8'h00;
    always @(posedge ref_clk_i)
        ring <= gate_i ? 8'h00 : ring + 8'h01;
    // Aux winding below threshold while on, damped, shorted or in a ringing trough
    assign valley_o = gate_i | damped_i | wshort_i | (ring >= 8'h40 && ring[4]);
    assign wshort_o = wshort_i;
    assign cs_low_o = cs_short_i | !gate_i;
    assign above_2p4_o = line_mv_i > 13'h0960;
    assign above_2p3_o = line_mv_i > 13'h08FC;
    assign above_1p0_o = line_mv_i > 13'h03E8;
    assign above_0p9_o = line_mv_i > 13'h0384;
endmodule // vsf_analog_model

//--- vsf_top_assertions.sv
// Purpose: Port level assertions for vsf_top
// Assumes: Comparator levels pass two sync flops
// Notes: Fault bounds carry a few cycles of margin
`timescale 1ns/100ps
module vsf_top_checker
    import vsf_pkg::*;
#(
    parameter int unsigned WSHORT_CYCLES = WSHORT_CYC,
    parameter int unsigned RESTART_CYCLES = RESTART_CYC,
    parameter int unsigned BROWNOUT_CYCLES = BROWNOUT_CYC
)
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic winding_short_cmp_i,
    input wire logic line_above_0p9_i,
    input wire logic cs_low_cmp_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic gate_drive_out_o,
    input wire logic ffwd_en_o,
    input wire logic irq_o
);
    int unsigned wcnt;
    int unsigned bcnt;
    int unsigned ccnt;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    // Consecutive cycles of each fault condition
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wcnt <= 0;
            bcnt <= 0;
            ccnt <= 0;
        end
        else
        begin
            wcnt <= winding_short_cmp_i ? wcnt + 1 : 0;
            bcnt <= line_above_0p9_i ? 0 : bcnt + 1;
            ccnt <= (gate_drive_out_o && cs_low_cmp_i) ? ccnt + 1 : 0;
        end
    end
    ready_after_access_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("no ready one cycle after access");
    ready_single_a: assert property (pready_o |-> $past(penable_i) ##1 !pready_o)
        else $error("ready not a single pulse after access");
    err_unmapped_a: assert property (psel_i && penable_i && !pready_o && paddr_i > REG_STATE
        |=> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access without error");
    rdata_quiet_a: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
        else $error("read data or error outside answer");
    ffwd_gate_a: assert property (ffwd_en_o |-> gate_drive_out_o)
        else $error("feed-forward on with gate off");
    wshort_stop_a: assert property (wcnt > WSHORT_CYCLES + 6 |-> !gate_drive_out_o)
        else $error("gate on after winding short time");
    brownout_stop_a: assert property (bcnt > BROWNOUT_CYCLES + 6 |-> !gate_drive_out_o)
        else $error("gate on after brown-out time");
    cs_short_stop_a: assert property (ccnt > BLANK_CYC + 6 |-> !gate_drive_out_o)
        else $error("gate on with sense low after blanking");
    cover property ($rose(gate_drive_out_o));
    cover property (pslverr_o);
    cover property ($rose(irq_o));
endmodule // vsf_top_checker

bind vsf_top vsf_top_checker #(.WSHORT_CYCLES(WSHORT_CYCLES), .RESTART_CYCLES(RESTART_CYCLES),
    .BROWNOUT_CYCLES(BROWNOUT_CYCLES)) chk (.ref_clk_i, .rst_i, .winding_short_cmp_i,
    .line_above_0p9_i, .cs_low_cmp_i, .psel_i, .penable_i, .paddr_i, .prdata_o, .pready_o,
    .pslverr_o, .gate_drive_out_o, .ffwd_en_o, .irq_o);

//--- tb_valley_select_fault_logic.sv
// Purpose: Self-checking bench for vsf_top over APB
// Assumes: Short fault counts set by parameters
// Notes: Comparators come from vsf_analog_model, except the supply levels driven by the bench
`timescale 1ns/100ps
module tb_valley_select_fault_logic;
    import vsf_pkg::*;
    localparam int WS = 50;
    localparam int RS = 100;
    localparam int BO = 40;
    logic ref_clk_i, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic supply_unlatch_i = 1'b0, supply_on_i = 1'b1, damped = 1'b0, wshort = 1'b0;
    logic cs_short = 1'b0, valley_cmp_i, winding_short_cmp_i, line_above_2p4_i;
    logic line_above_2p3_i, line_above_1p0_i, line_above_0p9_i, cs_low_cmp_i, rerr;
    logic pready_o, pslverr_o, gate_drive_out_o, ffwd_en_o, irq_o;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rdata;
    logic [12:0] line_mv = 13'h05DC;
    logic [3:0] v;
    int errors = 0, comparisons = 0, cycles = 0;
    logic [6:0] sp_tab [11] = '{7'h64, 7'h4A, 7'h31, 7'h1D, 7'h0E, 7'h05, 7'h07, 7'h08, 7'h14,
        7'h4C, 7'h4E};
    logic [2:0] band_tab [11] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h4, 3'h3, 3'h1, 3'h0};
    logic [3:0] lo_tab [6] = '{4'h1, 4'h2, 4'h4, 4'h7, 4'hB, 4'hD};
    logic [3:0] hi_tab [6] = '{4'h2, 4'h3, 4'h5, 4'h8, 4'hC, 4'hF};
    logic [12:0] ln_tab [4] = '{13'h092E, 13'h08CA, 13'h092E, 13'h0992};
    logic hr_tab [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic [31:0] rst_tab [5] = '{32'h0, 32'h64, 32'h64, 32'h0, 32'h0};

    vsf_top #(.WSHORT_CYCLES(WS), .RESTART_CYCLES(RS), .BROWNOUT_CYCLES(BO)) dut (.ref_clk_i,
        .rst_i, .valley_cmp_i, .winding_short_cmp_i, .line_above_2p4_i, .line_above_2p3_i,
        .line_above_1p0_i, .line_above_0p9_i, .cs_low_cmp_i, .supply_unlatch_i, .supply_on_i,
        .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .gate_drive_out_o, .ffwd_en_o, .irq_o);
    vsf_analog_model model (.ref_clk_i, .gate_i(gate_drive_out_o), .damped_i(damped),
        .wshort_i(wshort), .cs_short_i(cs_short), .line_mv_i(line_mv), .valley_o(valley_cmp_i),
        .wshort_o(winding_short_cmp_i), .above_2p4_o(line_above_2p4_i),
        .above_2p3_o(line_above_2p3_i), .above_1p0_o(line_above_1p0_i),
        .above_0p9_o(line_above_0p9_i), .cs_low_o(cs_low_cmp_i));

    task automatic report_and_stop();
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        @(posedge ref_clk_i);
        while (pready_o !== 1'b1)
            @(posedge ref_clk_i);
        rdata = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rdata & m, e);
    endtask
    task automatic st(input logic [2:0] e);
        rd(REG_STATE, 32'h0700, {21'h0, e, 8'h00});
    endtask
    task automatic wait_gate();
        while (gate_drive_out_o !== 1'b0)
            tick(1);
        while (gate_drive_out_o !== 1'b1)
            tick(1);
    endtask
    task automatic pin(input logic s, input logic e);
        tick(2);
        check({31'h0, s}, {31'h0, e});
    endtask

    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            errors++;
            report_and_stop();
        end
    end

    initial
    begin
        tick(20);
        rst_i <= 1'b0;
        tick(1);
        for (int i = 0; i < 5; i++)
            rd(8'(4 * i), 32'hFFFF_FFFF, rst_tab[i]);
        apb(1'b0, 8'h40, 32'h0);
        check({rdata[30:0], rerr}, 32'h1);
        apb(1'b1, REG_STATE, 32'hFFFF_FFFF);
        st(3'h0);
        for (int h = 0; h < 2; h++)
        begin
            line_mv <= h ? 13'h0BB8 : 13'h05DC;
            for (int i = 0; i < 11; i++)
            begin
                apb(1'b1, REG_SETPOINT, {25'h0, sp_tab[i]});
                tick(10);
                v = h ? hi_tab[band_tab[i]] : lo_tab[band_tab[i]];
                rd(REG_STATE, 32'hFF, {24'h0, band_tab[i], h[0], v});
            end
        end
        for (int i = 0; i < 4; i++)
        begin
            line_mv <= ln_tab[i];
            tick(10);
            rd(REG_STATE, 32'h10, {27'h0, hr_tab[i], 4'h0});
        end
        apb(1'b1, REG_ONTIME, 32'h3C);
        apb(1'b1, REG_CTRL, 32'h1);
        wait_gate();
        rd(REG_STATUS, 32'h10, 32'h10);
        damped <= 1'b1;
        apb(1'b1, REG_STATUS, 32'h1F);
        tick(480);
        rd(REG_STATUS, 32'h8, 32'h0);
        tick(300);
        rd(REG_STATUS, 32'h8, 32'h8);
        wait_gate();
        damped <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            line_mv <= i[0] ? 13'h03B6 : 13'h0352;
            tick(BO / 2);
        end
        line_mv <= 13'h03B6;
        st(3'h1);
        line_mv <= 13'h0352;
        tick(BO + 20);
        st(3'h4);
        line_mv <= 13'h03B6;
        tick(20);
        st(3'h4);
        rd(REG_STATUS, 32'h2, 32'h2);
        apb(1'b1, REG_MASK, 32'h2);
        pin(irq_o, 1'b1);
        apb(1'b1, REG_MASK, 32'h0);
        pin(irq_o, 1'b0);
        apb(1'b1, REG_MASK, 32'h2);
        apb(1'b1, REG_STATUS, 32'h2);
        pin(irq_o, 1'b0);
        line_mv <= 13'h04B0;
        tick(10);
        st(3'h1);
        wshort <= 1'b1;
        tick(WS - 15);
        st(3'h1);
        tick(20);
        st(3'h2);
        rd(REG_STATUS, 32'h1, 32'h1);
        wshort <= 1'b0;
        tick(RS - 40);
        st(3'h2);
        tick(50);
        st(3'h1);
        apb(1'b1, REG_CTRL, 32'h3);
        wshort <= 1'b1;
        tick(WS + 20);
        st(3'h3);
        wshort <= 1'b0;
        tick(RS + 50);
        st(3'h3);
        supply_unlatch_i <= 1'b1;
        tick(5);
        supply_unlatch_i <= 1'b0;
        tick(10);
        st(3'h1);
        cs_short <= 1'b1;
        wait_gate();
        tick(60);
        st(3'h5);
        cs_short <= 1'b0;
        tick(50);
        st(3'h5);
        supply_on_i <= 1'b0;
        tick(5);
        supply_on_i <= 1'b1;
        tick(10);
        st(3'h1);
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, REG_SETPOINT, 32'h6 + i);
            wait_gate();
            pin(ffwd_en_o, i[0]);
        end
        report_and_stop();
    end
endmodule // tb_valley_select_fault_logic
